// ---- hdl/pcseq_ram_port.sv ----
// registered data RAM port driver for the program stack
`timescale 1ns/10ps
module pcseq_ram_port
  import pcseq_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  pcseq_ram_if.port req, // request from sequencer
  output logic ram_wr_o, // write strobe
  output logic ram_rd_o, // read strobe
  output logic [SP_W-1:0] ram_addr_o, // ram address
  output logic [7:0] ram_wdata_o // write data
);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_wr_o <= 1'b0;
      ram_rd_o <= 1'b0;
      ram_addr_o <= SP_RST;
      ram_wdata_o <= 8'h00;
    end else begin
      ram_wr_o <= req.wr;
      ram_rd_o <= req.rd;
      ram_addr_o <= req.addr;
      ram_wdata_o <= req.wdata;
    end
  end
endmodule

// ---- hdl/pcseq_top.sv ----
// program counter sequencer with program stack push and pop
`timescale 1ns/10ps
module pcseq_top
  import pcseq_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic advance_i, // instruction fetched, advance counter
  input wire logic two_byte_i, // fetched instruction is two bytes
  input wire logic page_advance_instruction_i, // page-advance executed
  input wire logic call_i, // subroutine call
  input wire logic irq_ack_i, // interrupt acknowledge
  input wire logic [PC_W-1:0] target_i, // call or vector target
  input wire logic interrupt_return_instruction_i, // restore pc and flags
  input wire logic subroutine_return_instruction_i, // restore pc only
  input wire logic carry_i, // current carry flag
  input wire logic zero_i, // current zero flag
  input wire logic [7:0] ram_rdata_i, // data RAM read data, next cycle
  output logic [PC_W-1:0] program_counter_o, // fetch address
  output logic [SP_W-1:0] program_stack_pointer_o, // stack pointer
  output logic flags_load_o, // pulse: load carry and zero
  output logic carry_o, // restored carry
  output logic zero_o, // restored zero
  output logic int_enable_o, // pulse: re-enable interrupts
  output logic busy_o, // stack sequence in progress
  output logic ram_wr_o, // ram write strobe
  output logic ram_rd_o, // ram read strobe
  output logic [SP_W-1:0] ram_addr_o, // ram address
  output logic [7:0] ram_wdata_o // ram write data
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pcseq_state_e state_reg;
  logic [PC_W-1:0] pc_reg;
  logic [SP_W-1:0] sp_reg;
  logic [7:0] byte1_reg;
  logic [7:0] byte2_reg;
  logic with_flags_reg;
  logic rd_pend_reg;
  logic flags_reg;
  logic c_reg;
  logic z_reg;
  logic ien_reg;
  logic busy_reg;
  pcseq_ram_if ram ();

  // low byte value at the start of a fresh page
  localparam logic [LO_W-1:0] LO_RST_ZERO = 8'h00;

  function automatic logic [LO_W-1:0] step_len(input logic two);
    step_len = two ? LO_TWO : LO_ONE;
  endfunction

  // states that drive a stack write
  function automatic logic is_push(input pcseq_state_e st);
    is_push = (st == PCSEQ_PUSH1) || (st == PCSEQ_PUSH2);
  endfunction

  // states that wait on a stack read
  function automatic logic is_pop(input pcseq_state_e st);
    is_pop = (st == PCSEQ_POP2) || (st == PCSEQ_POP1);
  endfunction

  wire idle = (state_reg == PCSEQ_IDLE);
  wire push_req = idle && (call_i || irq_ack_i);
  wire pop_req = idle && (interrupt_return_instruction_i || subroutine_return_instruction_i);
  // low stack byte stands on the read data in this cycle
  wire pop_land = (state_reg == PCSEQ_POP1) && rd_pend_reg;

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_reg <= PC_RST; // [RULE2] [RULE1]
    end else if (push_req) begin
      pc_reg <= target_i;
    end else if (pop_land) begin
      pc_reg <= {byte2_reg[HI_W-1:0], ram_rdata_i}; // [RULE7] [RULE10]
    end else if (pop_req) begin
      pc_reg <= pc_reg; // a starting return owns the counter, advances in this cycle are dropped
    end else if (idle && page_advance_instruction_i) begin
      pc_reg[PC_W-1:LO_W] <= pc_reg[PC_W-1:LO_W] + HI_ONE; // [RULE4]
      pc_reg[LO_W-1:0] <= LO_RST_ZERO;
    end else if (idle && advance_i) begin
      pc_reg[LO_W-1:0] <= pc_reg[LO_W-1:0] + step_len(two_byte_i); // [RULE3] [RULE5]
    end
  end

  // ---------------------------------------------------------------
  // stack sequencing state
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= PCSEQ_IDLE;
    end else begin
      case (state_reg)
        PCSEQ_IDLE: begin
          if (push_req) begin
            state_reg <= PCSEQ_PUSH1;
          end else if (pop_req) begin
            state_reg <= PCSEQ_POP2;
          end
        end
        PCSEQ_PUSH1: state_reg <= PCSEQ_PUSH2;
        PCSEQ_PUSH2: state_reg <= PCSEQ_IDLE;
        PCSEQ_POP2: begin
          if (rd_pend_reg) begin
            state_reg <= PCSEQ_POP1;
          end
        end
        PCSEQ_POP1: begin
          if (rd_pend_reg) begin
            state_reg <= PCSEQ_DONE;
          end
        end
        PCSEQ_DONE: state_reg <= PCSEQ_IDLE;
        default: state_reg <= PCSEQ_IDLE;
      endcase
    end
  end

  // read wait flag: ram data arrives one cycle after the request
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= is_pop(state_reg) && !rd_pend_reg;
    end
  end

  // ---------------------------------------------------------------
  // program stack pointer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_reg <= SP_RST; // [RULE11]
    end else if (pop_req && !push_req) begin
      sp_reg <= sp_reg - SP_ONE; // [RULE9] [RULE10]
    end else if (state_reg == PCSEQ_POP2 && rd_pend_reg) begin
      sp_reg <= sp_reg - SP_ONE; // [RULE9]
    end else if (is_push(state_reg)) begin
      sp_reg <= sp_reg + SP_ONE; // [RULE9]
    end
  end

  // ---------------------------------------------------------------
  // saved state bytes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte1_reg <= 8'h00;
      byte2_reg <= 8'h00;
    end else if (push_req) begin
      // pc already holds the next instruction address when the call is taken
      byte1_reg <= pc_reg[LO_W-1:0]; // [RULE6] [RULE12]
      byte2_reg <= {carry_i, zero_i, pc_reg[PC_W-1:LO_W]}; // [RULE6] [RULE12]
    end else if (state_reg == PCSEQ_POP2 && rd_pend_reg) begin
      byte2_reg <= ram_rdata_i; // [RULE9]
    end
  end

  // return kind: only the interrupt return reloads the flags
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      with_flags_reg <= 1'b0;
    end else if (pop_req && !push_req) begin
      with_flags_reg <= interrupt_return_instruction_i; // [RULE7] [RULE10]
    end
  end

  // ---------------------------------------------------------------
  // busy flag, follows the next state so it matches the state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
    end else if (idle) begin
      busy_reg <= push_req || pop_req;
    end else begin
      busy_reg <= (state_reg == PCSEQ_PUSH1) || is_pop(state_reg);
    end
  end

  // ---------------------------------------------------------------
  // restored flags and interrupt enable
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_reg <= 1'b0;
      c_reg <= 1'b0;
      z_reg <= 1'b0;
      ien_reg <= 1'b0;
    end else begin
      flags_reg <= 1'b0;
      ien_reg <= 1'b0;
      if (pop_land && with_flags_reg) begin
        flags_reg <= 1'b1; // [RULE7]
        c_reg <= byte2_reg[B2_CARRY];
        z_reg <= byte2_reg[B2_ZERO];
      end
      if (state_reg == PCSEQ_DONE && with_flags_reg) begin
        ien_reg <= 1'b1; // [RULE9]
      end
    end
  end

  // ---------------------------------------------------------------
  // ram request; counter itself has no firmware port
  // ---------------------------------------------------------------
  assign ram.wr = is_push(state_reg); // [RULE8]
  assign ram.rd = is_pop(state_reg) && !rd_pend_reg;
  assign ram.addr = sp_reg;
  assign ram.wdata = (state_reg == PCSEQ_PUSH1) ? byte1_reg : byte2_reg;

  pcseq_ram_port u_port (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .req(ram),
    .ram_wr_o(ram_wr_o),
    .ram_rd_o(ram_rd_o),
    .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o)
  );

  assign program_counter_o = pc_reg;
  assign program_stack_pointer_o = sp_reg;
  assign flags_load_o = flags_reg;
  assign carry_o = c_reg;
  assign zero_o = z_reg;
  assign int_enable_o = ien_reg;
  assign busy_o = busy_reg;
endmodule

// ---- shared/pcseq_pkg.sv ----
// constants and types shared by the program counter sequencer
// How it works
// RULE1: a fourteen-bit program counter addresses up to sixteen kilobytes of program memory.
// RULE2: reset clears the program counter so the first fetch is from address zero.
// RULE3: ordinary sequencing advances only the low eight counter bits, wrapping within a page.
// RULE4: only the page-advance instruction increments the upper six counter bits.
// RULE5: the counter advances by one or two bytes, the length of each instruction.
// RULE6: interrupt acknowledge or call saves next address, carry and zero as two bytes.
// RULE7: only the interrupt return restores counter, carry and zero from the stack.
// RULE8: no firmware path to the counter; stack lives in data RAM from zero.
// RULE9: push writes at pointer then increments twice; interrupt return reverses, re-enables interrupts.
// RULE10: subroutine return restores the counter only, keeps flags, pointer drops by two.
// RULE11: reset sets the program stack pointer to zero, stack grows upward.
// RULE12: first byte holds low counter bits; second holds carry, zero, upper six bits.
package pcseq_pkg;
  localparam int PC_W = 14;
  localparam int LO_W = 8;
  localparam int HI_W = 6;
  localparam int SP_W = 8;
  localparam logic [PC_W-1:0] PC_RST = 14'h0000;
  localparam logic [SP_W-1:0] SP_RST = 8'h00;
  localparam logic [LO_W-1:0] LO_ONE = 8'h01;
  localparam logic [LO_W-1:0] LO_TWO = 8'h02;
  localparam logic [HI_W-1:0] HI_ONE = 6'h01;
  localparam logic [SP_W-1:0] SP_ONE = 8'h01;
  localparam int B2_CARRY = 7;
  localparam int B2_ZERO = 6;

  // sequencer states, gray coded along push and pop paths except the steps back to idle
  typedef enum logic [2:0] {
    PCSEQ_IDLE = 3'b000,
    PCSEQ_PUSH1 = 3'b001,
    PCSEQ_PUSH2 = 3'b011,
    PCSEQ_POP2 = 3'b010,
    PCSEQ_POP1 = 3'b110,
    PCSEQ_DONE = 3'b111
  } pcseq_state_e;
endpackage

// ---- shared/pcseq_ram_if.sv ----
// data RAM access bundle between sequencer and stack port
`timescale 1ns/10ps
interface pcseq_ram_if;
  import pcseq_pkg::*;
  logic wr;
  logic rd;
  logic [SP_W-1:0] addr;
  logic [7:0] wdata;
  modport seq (output wr, output rd, output addr, output wdata);
  modport port (input wr, input rd, input addr, input wdata);
endinterface

// ---- test/pcseq_ram_model.sv ----
// behavioural data RAM holding the program stack
`timescale 1ns/10ps
module pcseq_ram_model (
  input wire logic clk_i, // clock
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] addr_i, // address
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o // read data
);
  logic [7:0] mem [256];
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
  end
  // complement when not read, so stale data never matches
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule

// ---- test/pcseq_top_chk.sv ----
// concurrent checks on the sequencer top ports
`timescale 1ns/10ps
module pcseq_top_chk
  import pcseq_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic advance_i, // advance
  input wire logic two_byte_i, // length
  input wire logic page_advance_instruction_i, // page
  input wire logic call_i, // call
  input wire logic irq_ack_i, // irq
  input wire logic interrupt_return_instruction_i, // int return
  input wire logic subroutine_return_instruction_i, // sub return
  input wire logic [PC_W-1:0] program_counter_o, // counter
  input wire logic [SP_W-1:0] program_stack_pointer_o, // pointer
  input wire logic flags_load_o, // flags pulse
  input wire logic int_enable_o, // enable pulse
  input wire logic busy_o, // busy
  input wire logic ram_wr_o, // write
  input wire logic [SP_W-1:0] ram_addr_o // address
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic push, pop, two_q;
  logic [SP_W-1:0] sp_c;
  logic [PC_W-1:0] pc_q;
  assign push = (call_i | irq_ack_i) & !busy_o;
  assign pop = (interrupt_return_instruction_i | subroutine_return_instruction_i) & !busy_o
    & !(call_i | irq_ack_i);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) sp_c <= SP_RST;
    else if (push | pop) sp_c <= program_stack_pointer_o;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) {pc_q, two_q} <= '0;
    else {pc_q, two_q} <= {program_counter_o, two_byte_i};
  end
  sequence idle_req;
    !busy_o && !page_advance_instruction_i && !push && !pop;
  endsequence
  a_low_advance: assert property (idle_req and advance_i |=>
    program_counter_o == {pc_q[13:8], pc_q[7:0] + (two_q ? LO_TWO : LO_ONE)})
    else $error("low byte advance wrong");
  a_pc_hold: assert property (idle_req and !advance_i |=> program_counter_o == pc_q)
    else $error("counter moved without cause");
  a_page_step: assert property (page_advance_instruction_i && !busy_o && !push && !pop
    |=> program_counter_o == {pc_q[13:8] + HI_ONE, 8'h00}) else $error("page advance wrong");
  a_push_write: assert property (push |-> ##[1:3] (ram_wr_o && ram_addr_o == sp_c)
    ##1 (ram_wr_o && ram_addr_o == sp_c + SP_ONE)) else $error("push writes wrong");
  a_push_sp: assert property (push |-> ##[1:5] program_stack_pointer_o == sp_c + 8'h02)
    else $error("pointer not up by two");
  a_pop_sp: assert property (pop |-> ##[1:12] (!busy_o && program_stack_pointer_o == sp_c - 8'h02))
    else $error("pointer not down by two");
  a_sub_quiet: assert property (pop && !interrupt_return_instruction_i |->
    (!flags_load_o && !int_enable_o) [*8]) else $error("sub return touched flags");
  a_enable_follow: assert property (flags_load_o |=> int_enable_o)
    else $error("interrupt enable missing");
  a_reset_zero: assert property ($rose(rst_b_i) |->
    program_counter_o == PC_RST && program_stack_pointer_o == SP_RST) else $error("reset values");
endmodule

// ---- test/tb.sv ----
// self-checking bench for the program counter sequencer
`timescale 1ns/10ps
module tb;
  import pcseq_pkg::*;
  logic clk = 0, rst_b = 0, adv = 0, two = 0, pg = 0, cl = 0, irq = 0, ir = 0, sr = 0;
  logic c = 0, z = 0, fl, co, zo, ie, busy, rw, rr;
  logic [PC_W-1:0] tgt = '0, pc, exp_pc;
  logic [SP_W-1:0] sp, ra;
  logic [7:0] rd, wd;
  logic [15:0] sv [2];
  int error_cnt = 0, compares = 0, seed = 32'hC959, fl_n = 0, ie_n = 0;
  always #5 clk = ~clk;
  pcseq_top u_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .advance_i(adv), .two_byte_i(two),
    .page_advance_instruction_i(pg), .call_i(cl), .irq_ack_i(irq), .target_i(tgt),
    .interrupt_return_instruction_i(ir), .subroutine_return_instruction_i(sr), .carry_i(c),
    .zero_i(z), .ram_rdata_i(rd), .program_counter_o(pc), .program_stack_pointer_o(sp),
    .flags_load_o(fl), .carry_o(co), .zero_o(zo), .int_enable_o(ie), .busy_o(busy),
    .ram_wr_o(rw), .ram_rd_o(rr), .ram_addr_o(ra), .ram_wdata_o(wd));
  pcseq_ram_model u_ram (.clk_i(clk), .wr_i(rw), .rd_i(rr), .addr_i(ra), .wdata_i(wd),
    .rdata_o(rd));
  always @(posedge clk) begin
    if (fl === 1'b1) fl_n++;
    if (ie === 1'b1) ie_n++;
  end
  task automatic close_out;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [PC_W-1:0] nxt(input logic [PC_W-1:0] p, input logic a, t, g);
    if (g) return {p[13:8] + HI_ONE, 8'h00};
    if (a) return {p[13:8], p[7:0] + (t ? LO_TWO : LO_ONE)};
    return p;
  endfunction
  task automatic step(input logic a, input logic t, input logic p);
    @(negedge clk);
    {adv, two, pg} = {a, t, p};
    exp_pc = nxt(exp_pc, a, t, p);
    @(negedge clk);
    {adv, pg} = 2'b00;
    chk("pc", exp_pc, pc);
  endtask
  task automatic op(input int k);
    @(negedge clk);
    {cl, irq, ir, sr} = 4'h8 >> k;
    @(negedge clk);
    {cl, irq, ir, sr} = 4'h0;
    for (int i = 0; i < 30 && busy !== 1'b0; i++) @(negedge clk);
    // registered ram port lands the last stack write one cycle after busy drops
    @(negedge clk);
  endtask
  initial begin
    #100000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    exp_pc = PC_RST;
    @(negedge clk);
    chk("pc", PC_RST, pc);
    chk("sp", SP_RST, sp);
    for (int i = 0; i < 400; i++)
      step(1'($random(seed)), 1'($random(seed)), ($random(seed) & 63) == 0);
    while (pc[7:0] < 8'hFE) step(1, 0, 0);
    step(1, 1, 0);
    for (int k = 0; k < 2; k++) begin
      tgt = 14'($random(seed));
      {c, z} = {k[0], !k[0]};
      sv[k] = {c, z, exp_pc};
      op(k);
      chk("pc", tgt, pc);
      chk("sp", 16'(2 * k + 2), sp);
      chk("lo", sv[k][7:0], u_ram.mem[2 * k]);
      chk("hi", sv[k][15:8], u_ram.mem[2 * k + 1]);
      exp_pc = tgt;
      step(1, 1, 0);
    end
    op(2);
    chk("pc", sv[1][13:0], pc);
    chk("flags", sv[1][15:14], {co, zo});
    chk("pulses", 16'h0101, {8'(fl_n), 8'(ie_n)});
    op(3);
    chk("pc", sv[0][13:0], pc);
    chk("flags", {sv[1][15:14], 4'h1, 4'h1}, {co, zo, 4'(fl_n), 4'(ie_n)});
    chk("sp", SP_RST, sp);
    close_out;
  end
endmodule
bind pcseq_top pcseq_top_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i),
  .advance_i(advance_i),
  .two_byte_i(two_byte_i),
  .page_advance_instruction_i(page_advance_instruction_i),
  .call_i(call_i),
  .irq_ack_i(irq_ack_i),
  .interrupt_return_instruction_i(interrupt_return_instruction_i),
  .subroutine_return_instruction_i(subroutine_return_instruction_i),
  .program_counter_o(program_counter_o),
  .program_stack_pointer_o(program_stack_pointer_o),
  .flags_load_o(flags_load_o),
  .int_enable_o(int_enable_o),
  .busy_o(busy_o),
  .ram_wr_o(ram_wr_o),
  .ram_addr_o(ram_addr_o)
);
